//--- hdl/sadc_consts.vh
// Purpose: Shared constants of the serial ADC control port.
// Assumes: Master clock of 40 MHz; link pins sampled by that clock.
// Notes: Overview and tags follow.
// Overview of operation
// - Chip select falling clears frame counters and control state, enables link.
// - Chip select high makes serial clock and data input ignored.
// - Command nibble is captured on the first four rising serial clock edges.
// - Four configuration bits follow the command nibble on the next rising edges.
// - Data output is released while chip select is high, driven while low.
// - On chip select low the first result bit is driven at once.
// - Each later falling serial clock edge advances to the next result bit.
// - End-of-conversion output goes high once a conversion completes.
// - Selector offers eleven external inputs and three self-test levels.
// - Link uses clock idle low with data captured on rising edges.
// - Result may be sent top bit first or bottom bit first.
// - Result is 12 bits; host chooses the output word length.
// - Result coding is straight binary or bipolar.
// - Sampling starts by itself in every frame.
// - End-of-conversion falls after last falling edge, stays low until result ready.
// - Eight input bits on first eight rising edges; address valid after fourth.
// - Sampling runs from fourth falling edge to the frame's last falling edge.
// - Last falling edge hands over to the internal conversion machine.
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

`define SADC_MCLK_MHZ 40
`define SADC_CONV_TIME_NS 1600
`define SADC_CONV_CYC ((`SADC_CONV_TIME_NS * `SADC_MCLK_MHZ + 999) / 1000)

`define SADC_RES_W 12
`define SADC_WORD_W 16
`define SADC_FIFO_DEPTH 4
`define SADC_CMD_BITS 4
`define SADC_IN_BITS 8

`define SADC_CFG_LEN_HI 3
`define SADC_CFG_LEN_LO 2
`define SADC_CFG_LSBF 1
`define SADC_CFG_BIPOLAR 0
`define SADC_CFG_RESET 4'h0

`define SADC_LEN_12 2'h0
`define SADC_LEN_8 2'h1
`define SADC_LEN_16 2'h2

`define SADC_CH_LAST_EXT 4'ha
`define SADC_CH_TEST_MID 4'hb
`define SADC_CH_TEST_LO 4'hc
`define SADC_CH_TEST_HI 4'hd
`define SADC_CODE_MID 12'h800
`define SADC_CODE_LO 12'h000
`define SADC_CODE_HI 12'hfff

`endif

//--- hdl/sadc_fifo.v
// Purpose: Small synchronous FIFO for conversion results.
// Assumes: Single clock; write and read may occur in the same cycle.
// Notes: Storage in flip-flops; full and empty come from an occupancy count.
`default_nettype none

module sadc_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire mclk,                   // Clock
    input wire reset_n,                // Async reset, active low
    input wire clk_en,                 // Freezes state while low
    input wire in_valid,               // Write request
    output wire in_ready,              // Room for a word
    input wire [WIDTH-1:0] in_data,    // Write data
    output wire out_valid,             // Word available
    input wire out_ready,              // Read request
    output wire [WIDTH-1:0] out_data   // Head word
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0] cnt_ff;
    wire do_wr;
    wire do_rd;
    integer i;

    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rd_ff];
    assign do_wr = in_valid & in_ready & clk_en;
    assign do_rd = out_valid & out_ready & clk_en;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_wr) begin
                mem_ff[wr_ff] <= in_data;
                wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- hdl/sadc_port.v
// Purpose: Serial host port and conversion control of a 12-bit ADC.
// Assumes: Link pins are asynchronous to mclk and sampled twice before use.
// Notes: Analog path is outside; its code arrives on conv_code.
`include "sadc_consts.vh"
`default_nettype none

module sadc_port #(
    parameter CONV_CYC = `SADC_CONV_CYC,
    parameter FIFO_DEPTH = `SADC_FIFO_DEPTH
) (
    input wire mclk,                   // 40 MHz clock
    input wire reset_n,                // Async reset, active low
    input wire clk_en,                 // Freezes all state while low
    input wire cs_n,                   // Chip select pin, active low
    input wire io_clk,                 // Serial clock pin
    input wire data_in,                // Serial data input pin
    input wire [11:0] conv_code,       // Code from the analog converter
    output reg data_out_ff,            // Serial data output value
    output reg data_out_oe_n_ff,       // Output enable, low while driving
    output reg eoc_ff,                 // End of conversion status
    output reg [3:0] chan_sel_ff,      // Selected input for the converter
    output reg sampling_ff,            // Sample switch closed
    output reg busy_ff,                // Conversion machine active
    output reg [3:0] cfg_ff            // Active configuration bits
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_PUSH = 2'h2;
    localparam W = `SADC_WORD_W;

    // Pin synchronisers
    reg cs_s1_ff;
    reg cs_s2_ff;
    reg cs_s3_ff;
    reg clk_s1_ff;
    reg clk_s2_ff;
    reg clk_s3_ff;
    reg din_s1_ff;
    reg din_s2_ff;

    // Frame state
    reg [3:0] rise_cnt_ff;
    reg [4:0] fall_cnt_ff;
    reg [7:0] in_shift_ff;
    reg [3:0] command_nibble_register_ff;
    reg [3:0] frame_chan_ff;
    reg [W-1:0] out_shift_ff;
    reg [W-1:0] last_word_ff;
    reg frame_done_ff;

    // Conversion state
    reg [1:0] state_ff;
    reg [15:0] conv_cnt_ff;
    reg [3:0] conv_chan_ff;
    reg [3:0] conv_cfg_ff;
    reg [W-1:0] word_ff;

    wire cs_low;
    wire cs_fall;
    wire cs_rise;
    wire sclk_rise;
    wire sclk_fall;
    wire [4:0] frame_len;
    wire last_fall;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [W-1:0] fifo_out_data;
    wire fifo_pop;
    wire push_valid;

    reg [11:0] raw_code;
    reg [11:0] coded;
    reg [W-1:0] nxt_word;
    wire [11:0] coded_rev;
    wire [7:0] top8_rev;

    assign cs_low = ~cs_s2_ff;
    assign cs_fall = cs_s3_ff & ~cs_s2_ff;
    assign cs_rise = ~cs_s3_ff & cs_s2_ff;
    // Edges count only inside a frame and not in its first cycle
    assign sclk_rise = cs_low & ~cs_fall & ~clk_s3_ff & clk_s2_ff;
    assign sclk_fall = cs_low & ~cs_fall & clk_s3_ff & ~clk_s2_ff;

    // Word length chosen by the active configuration
    assign frame_len = (cfg_ff[`SADC_CFG_LEN_HI:`SADC_CFG_LEN_LO] == `SADC_LEN_8) ? 5'd8 :
                       (cfg_ff[`SADC_CFG_LEN_HI:`SADC_CFG_LEN_LO] == `SADC_LEN_16) ? 5'd16 :
                       5'd12;
    assign last_fall = sclk_fall & ~frame_done_ff & (fall_cnt_ff + 5'd1 == frame_len);

    assign fifo_pop = cs_fall & fifo_out_valid;
    assign push_valid = (state_ff == ST_PUSH);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            din_s1_ff <= 1'b0;
            din_s2_ff <= 1'b0;
        end else if (clk_en) begin
            cs_s1_ff <= cs_n;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            clk_s1_ff <= io_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            din_s1_ff <= data_in;
            din_s2_ff <= din_s1_ff;
        end
    end

    // Input side: command nibble then configuration bits, top bit first
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_ff <= 4'h0;
            in_shift_ff <= 8'h00;
            command_nibble_register_ff <= 4'h0;
            chan_sel_ff <= 4'h0;
        end else if (clk_en) begin
            if (cs_fall) begin
                rise_cnt_ff <= 4'h0;
                in_shift_ff <= 8'h00;
            end else if (sclk_rise && rise_cnt_ff != 4'd8) begin
                rise_cnt_ff <= rise_cnt_ff + 4'd1;
                in_shift_ff <= {in_shift_ff[6:0], din_s2_ff};
                if (rise_cnt_ff == 4'd3) begin
                    command_nibble_register_ff <= {in_shift_ff[2:0], din_s2_ff};
                    chan_sel_ff <= {in_shift_ff[2:0], din_s2_ff};
                end
            end
        end
    end

    // Output side: first bit at frame start, next bit on each falling edge
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fall_cnt_ff <= 5'h00;
            out_shift_ff <= {W{1'b0}};
            last_word_ff <= {W{1'b0}};
            data_out_ff <= 1'b0;
            data_out_oe_n_ff <= 1'b1;
            frame_done_ff <= 1'b0;
            sampling_ff <= 1'b0;
            frame_chan_ff <= 4'h0;
        end else if (clk_en) begin
            data_out_oe_n_ff <= cs_s2_ff;
            if (cs_fall) begin
                fall_cnt_ff <= 5'h00;
                frame_done_ff <= 1'b0;
                sampling_ff <= 1'b0;
                if (fifo_out_valid) begin
                    out_shift_ff <= fifo_out_data;
                    last_word_ff <= fifo_out_data;
                    data_out_ff <= fifo_out_data[W-1];
                end else begin
                    out_shift_ff <= last_word_ff;
                    data_out_ff <= last_word_ff[W-1];
                end
            end else if (sclk_fall && !frame_done_ff) begin
                fall_cnt_ff <= fall_cnt_ff + 5'd1;
                out_shift_ff <= {out_shift_ff[W-2:0], 1'b0};
                data_out_ff <= out_shift_ff[W-2];
                if (fall_cnt_ff == 5'd3) begin
                    sampling_ff <= 1'b1;
                end
                if (last_fall) begin
                    sampling_ff <= 1'b0;
                    frame_done_ff <= 1'b1;
                    frame_chan_ff <= command_nibble_register_ff;
                end
            end else if (cs_rise && !frame_done_ff) begin
                sampling_ff <= 1'b0;
            end
        end
    end

    // Configuration takes effect at the end of the frame that carried it
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ff <= `SADC_CFG_RESET;
        end else if (clk_en && last_fall && rise_cnt_ff == 4'd8) begin
            cfg_ff <= in_shift_ff[3:0];
        end
    end

    // Self-test levels replace the analog code
    always @* begin
        case (conv_chan_ff)
            `SADC_CH_TEST_MID: raw_code = `SADC_CODE_MID;
            `SADC_CH_TEST_LO: raw_code = `SADC_CODE_LO;
            `SADC_CH_TEST_HI: raw_code = `SADC_CODE_HI;
            default: raw_code = (conv_chan_ff <= `SADC_CH_LAST_EXT) ? conv_code : 12'h000;
        endcase
        // Bipolar coding flips the top bit of the straight code
        coded = conv_cfg_ff[`SADC_CFG_BIPOLAR] ? {~raw_code[11], raw_code[10:0]} : raw_code;
    end

    genvar g;
    generate
        for (g = 0; g < 12; g = g + 1) begin : g_rev12
            assign coded_rev[g] = coded[11-g];
        end
        for (g = 0; g < 8; g = g + 1) begin : g_rev8
            assign top8_rev[g] = coded[11-g];
        end
    endgenerate

    // Shift word, left aligned, in the order the bits leave the port
    always @* begin
        nxt_word = {W{1'b0}};
        case (conv_cfg_ff[`SADC_CFG_LEN_HI:`SADC_CFG_LEN_LO])
            `SADC_LEN_8: begin
                if (conv_cfg_ff[`SADC_CFG_LSBF]) begin
                    nxt_word = {top8_rev, 8'h00};
                end else begin
                    nxt_word = {coded[11:4], 8'h00};
                end
            end
            `SADC_LEN_16: begin
                if (conv_cfg_ff[`SADC_CFG_LSBF]) begin
                    nxt_word = {coded_rev, 4'h0};
                end else begin
                    nxt_word = {coded, 4'h0};
                end
            end
            default: begin
                if (conv_cfg_ff[`SADC_CFG_LSBF]) begin
                    nxt_word = {coded_rev, 4'h0};
                end else begin
                    nxt_word = {coded, 4'h0};
                end
            end
        endcase
    end

    // Conversion machine on the internal clock
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            conv_cnt_ff <= 16'h0000;
            conv_chan_ff <= 4'h0;
            conv_cfg_ff <= `SADC_CFG_RESET;
            word_ff <= {W{1'b0}};
            eoc_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else if (clk_en) begin
            case (state_ff)
                ST_IDLE: begin
                    if (last_fall) begin
                        state_ff <= ST_CONV;
                        conv_cnt_ff <= 16'h0000;
                        conv_chan_ff <= command_nibble_register_ff;
                        conv_cfg_ff <= (rise_cnt_ff == 4'd8) ? in_shift_ff[3:0] : cfg_ff;
                        eoc_ff <= 1'b0;
                        busy_ff <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (conv_cnt_ff == CONV_CYC[15:0] - 16'h0001) begin
                        state_ff <= ST_PUSH;
                        word_ff <= nxt_word;
                    end else begin
                        conv_cnt_ff <= conv_cnt_ff + 16'h0001;
                    end
                end
                ST_PUSH: begin
                    // Waits here while the result buffer is full
                    if (fifo_in_ready) begin
                        state_ff <= ST_IDLE;
                        eoc_ff <= 1'b1;
                        busy_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    sadc_fifo #(
        .WIDTH(W),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(word_ff),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );
endmodule

`default_nettype wire

//--- tb/sadc_port_assertions.sv
// Purpose: Timing checks on the ports of the serial ADC control port.
// Assumes: clk_en held high; link pins change away from mclk edges.
// Notes: Bound to every sadc_port instance.
`default_nettype none
module sadc_chk #(
    parameter int CONV_CYC = 40
) (
    input wire logic mclk,               // Clock
    input wire logic reset_n,            // Async reset, active low
    input wire logic cs_n,               // Chip select pin
    input wire logic io_clk,             // Serial clock pin
    input wire logic data_out_ff,        // Serial data output
    input wire logic data_out_oe_n_ff,   // Output enable, active low
    input wire logic eoc_ff,             // End of conversion
    input wire logic [3:0] chan_sel_ff,  // Selected input
    input wire logic sampling_ff,        // Sample switch
    input wire logic busy_ff,            // Conversion active
    input wire logic [3:0] cfg_ff        // Active configuration
);
    logic [7:0] busy_cnt_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) busy_cnt_ff <= 8'h00;
        else if (busy_ff) busy_cnt_ff <= busy_cnt_ff + 8'h01;
        else busy_cnt_ff <= 8'h00;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_oe_follows_cs: assert property (data_out_oe_n_ff == $past(cs_n, 3))
        else $error("output enable not following chip select");
    a_eoc_low_busy: assert property (busy_ff |-> !eoc_ff)
        else $error("end of conversion high during conversion");
    a_conv_start_state: assert property ($rose(busy_ff) |-> !eoc_ff && !sampling_ff)
        else $error("conversion start without sample end");
    a_conv_length: assert property (busy_ff |-> busy_cnt_ff <= CONV_CYC + 1)
        else $error("conversion runs too long");
    a_conv_done_eoc: assert property ($fell(busy_ff) |-> eoc_ff)
        else $error("end of conversion not raised when done");
    a_sample_in_frame: assert property (sampling_ff |-> !data_out_oe_n_ff)
        else $error("sampling outside a frame");
    a_cfg_in_frame: assert property (!$stable(cfg_ff) |-> !data_out_oe_n_ff)
        else $error("configuration changed outside a frame");
    a_chan_in_frame: assert property (!$stable(chan_sel_ff) |-> !data_out_oe_n_ff)
        else $error("channel changed outside a frame");
    a_data_idle_hold: assert property (data_out_oe_n_ff && $past(data_out_oe_n_ff)
        |-> $stable(data_out_ff))
        else $error("data output moved while released");
    a_data_on_fall: assert property (!$stable(data_out_ff) && !data_out_oe_n_ff
        && !$past(data_out_oe_n_ff) |-> !$past(io_clk, 2))
        else $error("data output moved away from a falling clock");
endmodule
bind sadc_port sadc_chk #(.CONV_CYC(CONV_CYC)) i_sadc_chk (.mclk(mclk), .reset_n(reset_n),
    .cs_n(cs_n), .io_clk(io_clk), .data_out_ff(data_out_ff),
    .data_out_oe_n_ff(data_out_oe_n_ff), .eoc_ff(eoc_ff), .chan_sel_ff(chan_sel_ff),
    .sampling_ff(sampling_ff), .busy_ff(busy_ff), .cfg_ff(cfg_ff));
`default_nettype wire

//--- tb/sadc_host.sv
// Purpose: Host side of the serial link, mode zero, 200 ns clock.
// Assumes: Caller starts each frame only when the device is idle.
// Notes: Released data input shows the inverse of its last value.
`default_nettype none
module sadc_host (
    output logic cs_n,                   // Chip select, active low
    output logic io_clk,                 // Serial clock
    output logic data_in,                // Serial data to device
    input wire logic data_out,           // Serial data from device
    input wire logic data_out_oe_n       // Device output enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        io_clk = 1'b0;
        data_in = 1'b0;
    end
    task automatic frame(input logic [7:0] din, input int nfall, output logic [15:0] got);
        int i;
        got = 16'h0000;
        #7 cs_n = 1'b0;
        #150;
        for (i = 0; i < nfall; i++) begin
            data_in = (i < 8) ? din[7 - i] : ~data_in;
            #100 io_clk = 1'b1;
            #99 got[15 - i] = data_out_oe_n ? 1'bx : data_out;
            #1 io_clk = 1'b0;
        end
        #100 cs_n = 1'b1;
        data_in = ~data_in;
    endtask
    // Clocks the link while deselected; the device must ignore it
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #100 io_clk = 1'b1;
            data_in = ~data_in;
            #100 io_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the serial ADC control port.
// Assumes: Short conversion count; host model drives the link.
// Notes: Each frame reads back the word converted in the frame before.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [11:0] conv_code = 12'h000;
    wire logic cs_n, io_clk, data_in, data_out_ff, data_out_oe_n_ff, eoc_ff;
    wire logic sampling_ff, busy_ff;
    wire logic [3:0] chan_sel_ff, cfg_ff;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'hc8e4c0f7;
    logic [15:0] prev = 16'h0000;
    logic [3:0] act_cfg = 4'h0;
    logic have_prev = 1'b0;
    logic [3:0] last_c = 4'h0;
    int ch;
    always #12.5 mclk = ~mclk;
    sadc_port #(.CONV_CYC(4), .FIFO_DEPTH(4)) i_sadc_port (.mclk(mclk), .reset_n(reset_n),
        .clk_en(clk_en), .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
        .conv_code(conv_code), .data_out_ff(data_out_ff),
        .data_out_oe_n_ff(data_out_oe_n_ff), .eoc_ff(eoc_ff), .chan_sel_ff(chan_sel_ff),
        .sampling_ff(sampling_ff), .busy_ff(busy_ff), .cfg_ff(cfg_ff));
    sadc_host i_sadc_host (.cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
        .data_out(data_out_ff), .data_out_oe_n(data_out_oe_n_ff));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [15:0] exp_word(logic [3:0] c, logic [3:0] cfg, logic [11:0] code);
        logic [11:0] v;
        logic [11:0] r;
        logic [7:0] r8;
        v = (c <= 4'ha) ? code : (c == 4'hb) ? 12'h800 : (c == 4'hd) ? 12'hfff : 12'h000;
        if (cfg[0]) v[11] = ~v[11];
        for (int i = 0; i < 12; i++) r[i] = v[11 - i];
        // Short word sends only the top eight bits; in bottom-first order the bottom one of them goes first
        for (int i = 0; i < 8; i++) r8[i] = v[11 - i];
        if (cfg[3:2] == 2'h1 && cfg[1]) return {r8, 8'h00};
        return cfg[1] ? {r, 4'h0} : {v, 4'h0};
    endfunction
    function automatic int len_of(logic [3:0] cfg);
        return (cfg[3:2] == 2'h1) ? 8 : (cfg[3:2] == 2'h2) ? 16 : 12;
    endfunction
    function automatic logic [3:0] rand_cfg();
        logic [1:0] l;
        logic [1:0] b;
        l = 2'(($random(seed) & 32'h7fffffff) % 3);
        b = 2'($random(seed));
        return {l, b};
    endfunction
    task automatic run_frame(input logic [3:0] c, input logic [3:0] cfg);
        logic [15:0] got;
        logic [15:0] mask;
        int n;
        int k;
        n = len_of(act_cfg);
        mask = 16'hffff << (16 - n);
        @(posedge mclk) conv_code <= 12'($random(seed));
        i_sadc_host.frame({c, cfg}, n, got);
        if (have_prev) check("data_out word", got & mask, prev & mask);
        check("chan_sel_ff", {12'h000, chan_sel_ff}, {12'h000, c});
        check("cfg_ff", {12'h000, cfg_ff}, {12'h000, cfg});
        for (k = 0; k < 200 && eoc_ff !== 1'b1; k++) @(posedge mclk);
        if (k == 200) begin
            n_mismatch++;
            results();
        end
        check("eoc_ff", {15'h0000, eoc_ff}, 16'h0001);
        check("busy_ff", {15'h0000, busy_ff}, 16'h0000);
        check("oe_n", {15'h0000, data_out_oe_n_ff}, 16'h0001);
        prev = exp_word(c, cfg, conv_code);
        act_cfg = cfg;
        last_c = c;
        have_prev = 1'b1;
        $display("frame chan %h cfg %h done", c, cfg);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        check("reset state", {eoc_ff, data_out_oe_n_ff, busy_ff, sampling_ff, cfg_ff,
            chan_sel_ff, 4'h0}, 16'hc000);
        for (ch = 0; ch < 16; ch++) run_frame(4'(ch), rand_cfg());
        run_frame(4'h3, 4'h8);
        run_frame(4'hd, 4'h4);
        run_frame(4'hb, 4'h3);
        repeat (12) run_frame(4'($random(seed)), rand_cfg());
        i_sadc_host.idle_clocks(6);
        repeat (4) @(posedge mclk);
        check("idle chan cfg", {8'h00, chan_sel_ff, cfg_ff}, {8'h00, last_c, act_cfg});
        $display("idle clock test done");
        results();
    end
endmodule
`default_nettype wire
